// ---- shared/resc_pkg.sv ----
// package for the regulator enable and status control block
// assumes a single 25 MHz clock domain and synchronous pin inputs
package resc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned ACK_WINDOW_S   = 5;
  localparam int unsigned ACK_WINDOW_CYC = ACK_WINDOW_S * CLK_HZ;

  // ----------------------------------------------------------------
  // serial port addresses and command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WR_STD = 8'h78;
  localparam logic [7:0] ADDR_RD_STD = 8'h79;
  localparam logic [7:0] ADDR_WR_MEM = 8'h7A;
  localparam logic [7:0] ADDR_RD_MEM = 8'h7B;
  // command register indices; no index is printed for these
  localparam logic [7:0] CMD_REG23   = 8'h0A;
  localparam logic [7:0] CMD_REG4    = 8'h0B;
  localparam logic [7:0] CMD_CLRIRQ  = 8'h1F;
  localparam logic [7:0] CMD_HRESET  = 8'h1E;
  localparam logic [7:0] CMD_PGCTL   = 8'h1D;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned B2_KEEP  = 0;
  localparam int unsigned B2_QUAL  = 1;
  localparam int unsigned B2_EN    = 2;
  localparam int unsigned B3_KEEP  = 3;
  localparam int unsigned B3_QUAL  = 4;
  localparam int unsigned B3_EN    = 5;
  localparam int unsigned B4_KEEP  = 0;
  localparam int unsigned B4_QUAL  = 1;
  localparam int unsigned B4_EN    = 2;
  localparam int unsigned B4_VLO   = 3;
  localparam int unsigned B4_VHI   = 4;
  localparam int unsigned PG_SLEWB = 0;
  localparam logic [7:0]  REG_RST  = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    V4_1V2 = 2'b00,
    V4_2V5 = 2'b01,
    V4_2V8 = 2'b10,
    V4_3V0 = 2'b11
  } resc_vsel_type;

  typedef enum logic [1:0] {
    WK_OFF  = 2'b00,
    WK_WAIT = 2'b01,
    WK_ON   = 2'b10
  } resc_wake_type;

  // one-cycle register write from the serial slave front end
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] cmd;
    logic [7:0] data;
  } resc_wr_type;

  // analog comparator results per linear regulator (2,3,4)
  typedef struct packed {
    logic [2:0] below_300mv;
    logic [2:0] below_power_good_out;
  } resc_ana_type;

endpackage : resc_pkg

// ---- core/resc_ctrl.sv ----
// enable, standby and status-pin logic for the three linear regulators
// assumes a serial slave front end delivering decoded writes and reads
// and analog comparators delivering levels synchronous to i_clk
//
// Notes on behaviour
// - reg two on: pin high or bit2
// - reg three on: pin high or bit5
// - keep-alive bit holds regulator through standby
// - qualify bit: start only below 300mV
// - standard variant: reg four pin or bit
// - memory variant: reg four by bit only
// - memory variant: bits 4:3 select voltage
// - control registers reset to zero
// - irq low on events, cleared by command
// - wake released by button or ack
// - reset low on button press, hard reset
// - reset low when always-on 8% low
// - power_good_out low when enabled rail low, slewing
// - power_good_out low when all rails off
// - answer only at variant slave addresses
// - button input low means pressed
// - enable pins active high, float low
// - serial supply loss resets command registers
module resc_ctrl
  import resc_pkg::*;
#(
  parameter bit          MEM_VARIANT = 1'b0,
  parameter int unsigned ACK_CYCLES  = ACK_WINDOW_CYC
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_serial_supply_low,
  input  wire resc_wr_type   i_wr,
  input  wire logic          i_rd_req,
  input  wire logic [7:0]    i_rd_addr,
  input  wire logic [7:0]    i_rd_cmd,
  input  wire logic          i_reg_two_enable_pin,
  input  wire logic          i_reg_three_enable_pin,
  input  wire logic          i_reg_four_enable_pin,
  input  wire logic          i_button_n,
  input  wire logic          i_host_power_ack_in,
  input  wire logic          i_standby,
  input  wire resc_ana_type  i_ana,
  input  wire logic          i_always_on_low8,
  input  wire logic          i_other_power_good_out_low,
  input  wire logic          i_dvs_slewing,
  input  wire logic          i_undervoltage,
  input  wire logic          i_overtemp,
  output logic [7:0]         o_rd_data,
  output logic               o_rd_valid,
  output logic [2:0]         o_reg_on,
  output resc_vsel_type      o_reg_four_vsel,
  output logic               o_irq_oe,
  output logic               o_wake_oe,
  output logic               o_reset_out_n_oe,
  output logic               o_power_good_out_oe
);

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [7:0] wr_addr_ok;
  logic [7:0] rd_addr_ok;
  logic       wr_ok;
  logic       rd_ok;
  logic       sw_rst;
  logic       wr_reg23;
  logic       wr_reg4;
  logic       wr_pgctl;
  logic       wr_clrirq;
  logic       wr_hreset;

  assign wr_addr_ok = MEM_VARIANT ? ADDR_WR_MEM : ADDR_WR_STD;
  assign rd_addr_ok = MEM_VARIANT ? ADDR_RD_MEM : ADDR_RD_STD;
  assign wr_ok      = i_wr.valid && (i_wr.addr == wr_addr_ok);
  assign rd_ok      = i_rd_req && (i_rd_addr == rd_addr_ok);
  // serial supply collapse acts like power-on for the command registers
  assign sw_rst     = i_serial_supply_low;

  // one strobe per command index; writes are dropped while the supply is low
  assign wr_reg23   = wr_ok && !sw_rst && (i_wr.cmd == CMD_REG23);
  assign wr_reg4    = wr_ok && !sw_rst && (i_wr.cmd == CMD_REG4);
  assign wr_pgctl   = wr_ok && !sw_rst && (i_wr.cmd == CMD_PGCTL);
  assign wr_clrirq  = wr_ok && !sw_rst && (i_wr.cmd == CMD_CLRIRQ);
  assign wr_hreset  = wr_ok && !sw_rst && (i_wr.cmd == CMD_HRESET);

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  logic [7:0] reg23_q;
  logic [7:0] reg4_q;
  logic [7:0] pgctl_q;
  logic       hreset_q;

  // unused upper bits are stored as zero so a read returns only live fields
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      reg23_q <= REG_RST;
    end else if (sw_rst) begin
      reg23_q <= REG_RST;
    end else if (wr_reg23) begin
      reg23_q <= {2'h0, i_wr.data[B3_EN:B2_KEEP]};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      reg4_q <= REG_RST;
    end else if (sw_rst) begin
      reg4_q <= REG_RST;
    end else if (wr_reg4) begin
      reg4_q <= {3'h0, i_wr.data[B4_VHI:B4_KEEP]};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pgctl_q <= REG_RST;
    end else if (sw_rst) begin
      pgctl_q <= REG_RST;
    end else if (wr_pgctl) begin
      pgctl_q <= {7'h00, i_wr.data[PG_SLEWB]};
    end
  end

  // hard reset pulse: one cycle per command write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hreset_q <= 1'b0;
    end else begin
      hreset_q <= wr_hreset;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= rd_ok;
    end
  end

  // data is captured only on a read, so it stands until the next one
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else if (rd_ok) begin
      case (i_rd_cmd)
        CMD_REG23: o_rd_data <= reg23_q;
        CMD_REG4:  o_rd_data <= reg4_q;
        CMD_PGCTL: o_rd_data <= pgctl_q;
        default:   o_rd_data <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // regulator enables
  // ----------------------------------------------------------------
  logic [2:0] want;
  logic [2:0] qual;
  logic [2:0] keep;
  logic [2:0] on_q;

  // pins read low when floating; the pull-down is outside this logic
  assign want[0] = i_reg_two_enable_pin || reg23_q[B2_EN];
  assign want[1] = i_reg_three_enable_pin || reg23_q[B3_EN];
  // memory variant has no pin for regulator four
  assign want[2] = MEM_VARIANT ? reg4_q[B4_EN]
                               : (i_reg_four_enable_pin || reg4_q[B4_EN]);
  assign qual    = {reg4_q[B4_QUAL], reg23_q[B3_QUAL], reg23_q[B2_QUAL]};
  assign keep    = {reg4_q[B4_KEEP], reg23_q[B3_KEEP], reg23_q[B2_KEEP]};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_reg
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          on_q[g] <= 1'b0;
        end else if (i_standby) begin
          // standby holds a kept regulator as it was, drops the rest
          if (!keep[g]) on_q[g] <= 1'b0;
        end else if (!want[g]) begin
          on_q[g] <= 1'b0;
        end else if (!on_q[g] && (!qual[g] || i_ana.below_300mv[g])) begin
          on_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  assign o_reg_on        = on_q;
  assign o_reg_four_vsel = MEM_VARIANT ? resc_vsel_type'(reg4_q[B4_VHI:B4_VLO])
                                       : V4_1V2;

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  logic irq_q;
  logic irq_evt;
  logic pg_low;
  logic pg_low_q;

  // only the edge into power_good_out-low is an event, so a rail that stays low
  // cannot raise the interrupt again right after the host has cleared it
  assign irq_evt = (pg_low && !pg_low_q) || i_undervoltage || i_overtemp;

  // power_good_out is low while everything is off, so the history starts low too;
  // otherwise a false event would follow every reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pg_low_q <= 1'b1;
    end else begin
      pg_low_q <= pg_low;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_q <= 1'b0;
    end else if (irq_evt) begin
      // an event in the clearing cycle wins
      irq_q <= 1'b1;
    end else if (wr_clrirq) begin
      irq_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wake
  // ----------------------------------------------------------------
  resc_wake_type wk_q;
  logic [$clog2(ACK_CYCLES+1)-1:0] ack_cnt_q;
  logic          press;

  assign press = !i_button_n;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wk_q <= WK_OFF;
    end else begin
      case (wk_q)
        WK_OFF: begin
          if (i_host_power_ack_in) begin
            wk_q <= WK_ON;
          end else if (press) begin
            wk_q <= WK_WAIT;
          end
        end
        WK_WAIT: begin
          // host must acknowledge within the window or wake drops
          if (i_host_power_ack_in) begin
            wk_q <= WK_ON;
          end else if (ack_cnt_q >= ($bits(ack_cnt_q))'(ACK_CYCLES - 1)) begin
            wk_q <= WK_OFF;
          end
        end
        WK_ON: begin
          if (!i_host_power_ack_in) begin
            wk_q <= WK_OFF;
          end
        end
        default: wk_q <= WK_OFF;
      endcase
    end
  end

  // counter runs only while waiting for the host acknowledge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_cnt_q <= '0;
    end else if (wk_q == WK_WAIT) begin
      ack_cnt_q <= ack_cnt_q + 1'b1;
    end else begin
      ack_cnt_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // open-drain status pins (oe low = pulled low)
  // ----------------------------------------------------------------
  logic pg_rail_low;
  logic pg_slew_low;
  logic pg_all_off;
  logic rst_pull;

  assign pg_rail_low = (|(on_q & i_ana.below_power_good_out)) || i_other_power_good_out_low;
  // the slewing pull-down can be masked by the power_good_out control register
  assign pg_slew_low = i_dvs_slewing && !pgctl_q[PG_SLEWB];
  assign pg_all_off  = (on_q == 3'b000);
  assign pg_low      = pg_rail_low || pg_slew_low || pg_all_off;
  // the pushbutton hard reset has no timing of its own: it follows the button
  assign rst_pull    = i_always_on_low8 || hreset_q || press;

  assign o_irq_oe            = !irq_q;
  assign o_wake_oe           = (wk_q != WK_OFF);
  assign o_reset_out_n_oe    = !rst_pull;
  assign o_power_good_out_oe = !pg_low;

endmodule : resc_ctrl

// ---- verification/resc_host_model.sv ----
// host model: decoded serial writes and reads towards the control block
// assumes the bench calls its tasks; signals change at falling edges
module resc_host_model
  import resc_pkg::*;
#(
  parameter bit MEM_VARIANT = 1'h1
) (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output resc_wr_type     o_wr,
  output logic            o_rd_req,
  output logic [7:0]      o_rd_addr,
  output logic [7:0]      o_rd_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr = '0;
    o_rd_req = 1'h0;
    o_rd_addr = 8'h00;
    o_rd_cmd = 8'h00;
  end
  // one write, held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
    @(negedge i_clk);
    o_wr = '{valid: 1'h1, addr: a, cmd: c, data: d};
    @(negedge i_clk);
    o_wr.valid = 1'h0;
  endtask : wr
  // request stands across one rising edge; the registered answer is taken
  // at the next falling edge, while its valid pulse still stands
  task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_rd_req = 1'h1;
    o_rd_addr = MEM_VARIANT ? ADDR_RD_MEM : ADDR_RD_STD;
    o_rd_cmd = c;
    @(negedge i_clk);
    d = i_rd_data;
    v = i_rd_valid;
    o_rd_req = 1'h0;
  endtask : rd
endmodule : resc_host_model

// ---- verification/resc_ctrl_properties.sv ----
// checker for the regulator control block ports
// assumes a bind to resc_ctrl, one clock domain
module resc_ctrl_properties
  import resc_pkg::*;
#(
  parameter bit MEM_VARIANT = 1'h0
) (
  input wire logic         i_clk,
  input wire logic         i_rst,
  input wire resc_wr_type  i_wr,
  input wire logic         i_reg_two_enable_pin,
  input wire logic         i_button_n,
  input wire logic         i_host_power_ack_in,
  input wire logic         i_standby,
  input wire resc_ana_type i_ana,
  input wire logic         i_always_on_low8,
  input wire logic         i_undervoltage,
  input wire logic         i_overtemp,
  input wire logic [2:0]   o_reg_on,
  input wire logic         o_irq_oe,
  input wire logic         o_wake_oe,
  input wire logic         o_reset_out_n_oe,
  input wire logic         o_power_good_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clr_wr;
  assign clr_wr = i_wr.valid && i_wr.cmd == CMD_CLRIRQ
    && i_wr.addr == (MEM_VARIANT ? ADDR_WR_MEM : ADDR_WR_STD);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_ack_held;
    i_host_power_ack_in [*2];
  endsequence
  a_reg_two_pin: assert property (
    i_reg_two_enable_pin && i_ana.below_300mv[0] && !i_standby |=> o_reg_on[0])
    else $error("reg two not on with pin high");
  a_irq_event: assert property (
    i_undervoltage || i_overtemp |=> !o_irq_oe) else $error("irq not pulled low");
  a_irq_latched: assert property (
    !o_irq_oe && !clr_wr |=> !o_irq_oe) else $error("irq released without clear");
  a_aon_reset: assert property (
    i_always_on_low8 |-> !o_reset_out_n_oe) else $error("reset out not low");
  a_button_reset: assert property (
    !i_button_n |-> !o_reset_out_n_oe) else $error("reset out not low on press");
  a_power_good_out_off: assert property (
    o_reg_on == 3'h0 |-> !o_power_good_out_oe) else $error("power_good_out high, all off");
  a_power_good_out_rail: assert property (
    |(o_reg_on & i_ana.below_power_good_out) |-> !o_power_good_out_oe) else $error("power_good_out high");
  a_wake_ack: assert property (
    s_ack_held |-> o_wake_oe) else $error("wake not released on ack");
  a_wake_drop: assert property (
    $fell(i_host_power_ack_in) && i_button_n |=> !o_wake_oe) else $error("wake held");
endmodule : resc_ctrl_properties
bind resc_ctrl resc_ctrl_properties #(.MEM_VARIANT(MEM_VARIANT)) u_resc_ctrl_properties (
  .i_clk, .i_rst, .i_wr, .i_reg_two_enable_pin, .i_button_n, .i_host_power_ack_in,
  .i_standby, .i_ana, .i_always_on_low8, .i_undervoltage, .i_overtemp, .o_reg_on,
  .o_irq_oe, .o_wake_oe, .o_reset_out_n_oe, .o_power_good_out_oe);

// ---- verification/resc_ctrl_tb_top.sv ----
// bench: memory variant, wake window shortened to 20 cycles
// assumes the host model for all register traffic
module resc_ctrl_tb_top;
  import resc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk = 1'h0, rst = 1'h1, sup_low = 1'h0, pin3 = 1'h0, pin4 = 1'h0;
  logic          btn_n = 1'h1, ack = 1'h0, stby = 1'h0, aon8 = 1'h0, uv = 1'h0, ot = 1'h0;
  resc_ana_type  ana = '{below_300mv: 3'h7, below_power_good_out: 3'h0};
  resc_wr_type   wr_s;
  resc_vsel_type vsel;
  logic          pin2 = 1'h0, opg = 1'h0, dvs = 1'h0;
  logic          rd_req, rd_valid, irq, wake, reset_out_n, pg, vld;
  logic [7:0]    rd_addr, rd_cmd, rd_data, rv;
  logic [2:0]    reg_on;
  int            n_errors = 0, n_tests = 0, cycles = 0;
  always #20 clk = ~clk;
  resc_ctrl #(.MEM_VARIANT(1'h1), .ACK_CYCLES(20)) u_resc_ctrl (.i_clk(clk), .i_rst(rst),
    .i_serial_supply_low(sup_low), .i_wr(wr_s), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
    .i_rd_cmd(rd_cmd), .i_reg_two_enable_pin(pin2), .i_reg_three_enable_pin(pin3),
    .i_reg_four_enable_pin(pin4), .i_button_n(btn_n), .i_host_power_ack_in(ack),
    .i_standby(stby), .i_ana(ana), .i_always_on_low8(aon8), .i_other_power_good_out_low(opg),
    .i_dvs_slewing(dvs), .i_undervoltage(uv), .i_overtemp(ot), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_reg_on(reg_on), .o_reg_four_vsel(vsel), .o_irq_oe(irq),
    .o_wake_oe(wake), .o_reset_out_n_oe(reset_out_n), .o_power_good_out_oe(pg));
  resc_host_model #(.MEM_VARIANT(1'h1)) u_resc_host_model (.i_clk(clk), .i_rd_data(rd_data),
    .i_rd_valid(rd_valid),
    .o_wr(wr_s), .o_rd_req(rd_req), .o_rd_addr(rd_addr), .o_rd_cmd(rd_cmd));
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_b
  task automatic chk_f(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t pin %b expected %b", $time, got, exp);
    end
  endtask : chk_f
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    u_resc_host_model.wr(ADDR_WR_MEM, c, d);
  endtask : wr
  task automatic rdc(input logic [7:0] c, input logic [7:0] e);
    u_resc_host_model.rd(c, rv, vld);
    chk_f(vld, 1'h1);
    chk_b(rv, e);
  endtask : rdc
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // the whole run needs about 110 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    cyc(4);
    rst = 1'h0;
    rdc(CMD_REG23, 8'h00);
    rdc(CMD_REG4, 8'h00);
    chk_f(pg, 1'h0);
    wr(CMD_REG23, 8'h24);
    cyc(2);
    chk_b({5'h00, reg_on}, 8'h03);
    ana.below_power_good_out = 3'h2;
    cyc(1);
    chk_f(pg, 1'h0);
    ana.below_power_good_out = 3'h0;
    u_resc_host_model.wr(ADDR_WR_STD, CMD_REG23, 8'h00);
    rdc(CMD_REG23, 8'h24);
    wr(CMD_REG23, 8'h00);
    pin3 = 1'h1;
    cyc(2);
    chk_b({5'h00, reg_on}, 8'h02);
    pin3 = 1'h0;
    ana.below_300mv = 3'h0;
    wr(CMD_REG23, 8'h06);
    cyc(2);
    chk_b({5'h00, reg_on}, 8'h00);
    ana.below_300mv = 3'h7;
    cyc(2);
    chk_b({5'h00, reg_on}, 8'h01);
    wr(CMD_REG23, 8'h2C);
    cyc(2);
    stby = 1'h1;
    cyc(2);
    chk_b({5'h00, reg_on}, 8'h02);
    stby = 1'h0;
    $display("test enables done");
    pin4 = 1'h1;
    wr(CMD_REG23, 8'h00);
    cyc(2);
    chk_b({5'h00, reg_on}, 8'h00);
    for (int v = 0; v < 4; v++) begin
      wr(CMD_REG4, {3'h0, v[1:0], 3'h4});
      cyc(2);
      chk_b({5'h00, reg_on}, 8'h04);
      chk_b({6'h00, vsel}, v[7:0]);
    end
    sup_low = 1'h1;
    cyc(1);
    sup_low = 1'h0;
    rdc(CMD_REG4, 8'h00);
    chk_b({6'h00, vsel}, 8'h00);
    pin4 = 1'h0;
    $display("test reg four done");
    for (int i = 0; i < 2; i++) begin
      wr(CMD_CLRIRQ, 8'h00);
      cyc(1);
      chk_f(irq, 1'h1);
      uv = (i == 0);
      ot = (i == 1);
      cyc(1);
      uv = 1'h0;
      ot = 1'h0;
      cyc(2);
      chk_f(irq, 1'h0);
    end
    pin2 = 1'h1;
    cyc(2);
    chk_b({5'h00, reg_on}, 8'h01);
    chk_f(pg, 1'h1);
    dvs = 1'h1;
    cyc(1);
    chk_f(pg, 1'h0);
    wr(CMD_PGCTL, 8'h01);
    chk_f(pg, 1'h1);
    rdc(CMD_PGCTL, 8'h01);
    dvs = 1'h0;
    opg = 1'h1;
    cyc(1);
    chk_f(pg, 1'h0);
    opg = 1'h0;
    wr(CMD_HRESET, 8'h00);
    chk_f(reset_out_n, 1'h0);
    cyc(1);
    chk_f(reset_out_n, 1'h1);
    pin2 = 1'h0;
    aon8 = 1'h1;
    cyc(1);
    chk_f(reset_out_n, 1'h0);
    aon8 = 1'h0;
    btn_n = 1'h0;
    cyc(1);
    chk_f(reset_out_n, 1'h0);
    btn_n = 1'h1;
    cyc(2);
    chk_f(wake, 1'h1);
    cyc(25);
    chk_f(wake, 1'h0);
    ack = 1'h1;
    cyc(2);
    chk_f(wake, 1'h1);
    ack = 1'h0;
    cyc(2);
    chk_f(wake, 1'h0);
    $display("test status pins done");
    tally_and_finish();
  end
endmodule : resc_ctrl_tb_top
